/* cssc_clock_source_select.sv */
// Clock source select configuration registers and routing
`timescale 1ns/1ns
`default_nettype none
//Operation
// - Priority bit picks primary input clock
// - Mode field: manual, non-revertive, revertive
// - Source field routes divider input clock
// - Divider one input, others PLL A default
// - Four loop filter slots chosen by pins
// - Slot bit picks divider configuration choice
// - Multiplier twice integer, plus add plus one when add is nonzero
module cssc_clock_source_select
    import cssc_pkg::*;
#(
    parameter int DIVIDERS = 6
) (
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  reg_write,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    input  wire logic                  multi_function_config_mode,
    input  wire logic                  config_pins_enable,
    input  wire logic [1:0]            config_select_pins,
    input  wire logic [11:0]           feedback_integer_field,
    input  wire logic [3:0]            feedback_fraction_add,
    input  wire logic                  crystal_reference_input,
    input  wire logic                  second_clock_input,
    input  wire logic                  crystal_good,
    input  wire logic                  second_good,
    input  wire logic                  pll_a_clock,
    input  wire logic                  pll_b_clock,
    input  wire logic                  pll_c_clock,
    output logic                       selected_input_clock,
    output logic                       second_input_active,
    output logic [DIVIDERS-1:0]        divider_clock,
    output logic [2*DIVIDERS-1:0]      divider_source_select,
    output logic [6:0]                 pll_c_loop_filter,
    output logic                       divider_config_choice,
    output logic [13:0]                pll_b_multiplier
);
    logic [7:0]  fb2_reg;
    logic [7:0]  fb3_reg;
    logic [7:0]  prio_reg;
    logic [7:0]  route_reg;
    logic [7:0]  lf_reg [4];
    logic        want_second_reg;
    logic        want_second_next;
    logic [7:0]  lf_sel;
    logic        lf_hit;
    logic [1:0]  lf_idx;
    logic [1:0]  slot;
    logic [1:0]  mode;
    logic        prio;
    logic        primary_good;
    logic        backup_good;
    logic        on_backup;
    logic [3:0]  src_clocks;
    logic [13:0] mult_next;

    assign prio = prio_reg[CSSC_PRIO_BIT];
    assign mode = prio_reg[CSSC_MODE_LSB +: 2];

    // Auto modes: leave a failed primary; revertive returns once primary is good
    assign primary_good = prio ? second_good : crystal_good;
    assign backup_good  = prio ? crystal_good : second_good;
    assign on_backup    = want_second_reg != prio;
    always_comb begin
        want_second_next = want_second_reg;
        case (mode)
            2'b10: begin
                if (!on_backup && !primary_good && backup_good)
                    want_second_next = !prio;
                else if (on_backup && !backup_good && primary_good)
                    want_second_next = prio;
            end
            2'b11: begin
                want_second_next = (!primary_good && backup_good) ? !prio : prio;
            end
            default: begin
                want_second_next = prio;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fb2_reg   <= CSSC_FB_RESET;
            fb3_reg   <= CSSC_FB_RESET;
            prio_reg  <= CSSC_PRIO_RESET;
            route_reg <= CSSC_ROUTE_RESET;
        end else if (reg_write) begin
            case (reg_addr)
                CSSC_FB_SLOT2_ADDR: fb2_reg <= reg_wdata;
                CSSC_FB_SLOT3_ADDR: fb3_reg <= reg_wdata;
                CSSC_PRIO_ADDR: prio_reg <= reg_wdata;
                CSSC_ROUTE_ADDR: route_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            want_second_reg <= 1'b0;
        end else begin
            want_second_reg <= want_second_next;
        end
    end

    // Loop filter slots occupy four consecutive addresses from slot zero
    assign lf_hit = reg_write && (reg_addr[7:2] == CSSC_LF_SLOT0_ADDR[7:2]);
    assign lf_idx = reg_addr[1:0];

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lf_reg <= '{default: CSSC_LF_RESET};
        end else if (lf_hit) begin
            lf_reg[lf_idx] <= reg_wdata;
        end
    end

    cssc_glitchless_mux u_input_mux (
        .clock    (clock),
        .reset    (reset),
        .select_b (want_second_reg),
        .clk_a    (crystal_reference_input),
        .clk_b    (second_clock_input),
        .active_b (second_input_active),
        .clk_out  (selected_input_clock)
    );

    // Slot zero when pins are disabled or outside the multi-function mode
    assign slot   = (multi_function_config_mode && config_pins_enable)
                    ? config_select_pins : 2'b00;
    assign lf_sel = lf_reg[slot];

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pll_c_loop_filter     <= 7'h00;
            divider_config_choice <= 1'b0;
        end else begin
            pll_c_loop_filter     <= lf_sel[6:0];
            divider_config_choice <= multi_function_config_mode
                                     && lf_sel[CSSC_ODIV_BIT];
        end
    end

    // Multiplier: twice integer, plus add plus one when add is nonzero
    assign mult_next = (feedback_fraction_add == 4'h0)
                       ? {1'b0, feedback_integer_field, 1'b0}
                       : 14'({1'b0, feedback_integer_field, 1'b0})
                         + 14'(feedback_fraction_add) + 14'h0001;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pll_b_multiplier <= 14'h0000;
        end else begin
            pll_b_multiplier <= mult_next;
        end
    end

    // Field order: divider1,2 in input register; 3..6 in routing register
    assign divider_source_select = 12'({route_reg, prio_reg[7:4]});
    assign src_clocks = {pll_c_clock, pll_b_clock, pll_a_clock, selected_input_clock};

    genvar d;
    generate
        for (d = 0; d < DIVIDERS; d++) begin : g_div
            assign divider_clock[d] = src_clocks[divider_source_select[2*d +: 2]];
        end
    endgenerate

    // Reserved bit reads back as written; software keeps it zero
    always_comb begin
        case (reg_addr)
            CSSC_FB_SLOT2_ADDR: reg_rdata = fb2_reg;
            CSSC_FB_SLOT3_ADDR: reg_rdata = fb3_reg;
            CSSC_PRIO_ADDR: reg_rdata = prio_reg;
            CSSC_ROUTE_ADDR: reg_rdata = route_reg;
            CSSC_LF_SLOT0_ADDR: reg_rdata = lf_reg[0];
            CSSC_LF_SLOT1_ADDR: reg_rdata = lf_reg[1];
            CSSC_LF_SLOT2_ADDR: reg_rdata = lf_reg[2];
            CSSC_LF_SLOT3_ADDR: reg_rdata = lf_reg[3];
            default: reg_rdata = 8'h00;
        endcase
    end

    manual_follow_a: assert property (@(posedge clock) disable iff (reset)
        (mode[1] == 1'b0) |=> (want_second_reg == $past(prio)))
        else $error("manual mode ignores priority");
    revert_back_a: assert property (@(posedge clock) disable iff (reset)
        (mode == 2'b11 && primary_good) |=> (want_second_reg == $past(prio)))
        else $error("revertive mode failed to return");
    nonrevert_hold_a: assert property (@(posedge clock) disable iff (reset)
        (mode == 2'b10 && on_backup && backup_good) |=> $stable(want_second_reg))
        else $error("non-revertive mode left backup");
    nonrevert_fail_a: assert property (@(posedge clock) disable iff (reset)
        (mode == 2'b10 && !on_backup && !primary_good && backup_good)
        |=> (want_second_reg == !$past(prio)))
        else $error("non-revertive mode kept failed input");
    route_input_a: assert property (@(posedge clock) disable iff (reset)
        (divider_source_select[1:0] == 2'b00) |-> (divider_clock[0] == selected_input_clock))
        else $error("divider one not on input clock");
    slot_pick_a: assert property (@(posedge clock) disable iff (reset)
        (multi_function_config_mode && config_pins_enable && config_select_pins == 2'b11)
        |=> (pll_c_loop_filter == $past(lf_reg[3][6:0])))
        else $error("pin selected slot not used");
    odiv_mode_a: assert property (@(posedge clock) disable iff (reset)
        (multi_function_config_mode && !config_pins_enable)
        |=> (divider_config_choice == $past(lf_reg[0][7])))
        else $error("divider choice not from slot zero");
    route_pick_a: assert property (@(posedge clock) disable iff (reset)
        (divider_source_select[3:2] == 2'b01) |-> (divider_clock[1] == pll_a_clock))
        else $error("divider routing wrong");
    slot_zero_a: assert property (@(posedge clock) disable iff (reset)
        !config_pins_enable |=> (pll_c_loop_filter == $past(lf_reg[0][6:0])))
        else $error("slot zero not used");
    odiv_pick_a: assert property (@(posedge clock) disable iff (reset)
        !multi_function_config_mode |=> !divider_config_choice)
        else $error("divider choice outside mode");
    mult_even_a: assert property (@(posedge clock) disable iff (reset)
        (feedback_fraction_add == 4'h0) |=> (pll_b_multiplier[0] == 1'b0))
        else $error("multiplier not even");
    switch_settle_a: assert property (@(posedge clock) disable iff (reset)
        $rose(want_second_reg) |-> ##[1:3] second_input_active)
        else $error("switchover did not settle");
endmodule : cssc_clock_source_select
`default_nettype wire

/* cssc_pkg.sv */
// Constants for the clock source select configuration slice
package cssc_pkg;
    localparam logic [7:0] CSSC_FB_SLOT2_ADDR  = 8'h32;
    localparam logic [7:0] CSSC_FB_SLOT3_ADDR  = 8'h33;
    localparam logic [7:0] CSSC_PRIO_ADDR      = 8'h34;
    localparam logic [7:0] CSSC_ROUTE_ADDR     = 8'h35;
    localparam logic [7:0] CSSC_LF_SLOT0_ADDR  = 8'h38;
    localparam logic [7:0] CSSC_LF_SLOT1_ADDR  = 8'h39;
    localparam logic [7:0] CSSC_LF_SLOT2_ADDR  = 8'h3a;
    localparam logic [7:0] CSSC_LF_SLOT3_ADDR  = 8'h3b;
    localparam logic [7:0] CSSC_FB_RESET       = 8'h00;
    localparam logic [7:0] CSSC_PRIO_RESET     = 8'h46;
    localparam logic [7:0] CSSC_ROUTE_RESET    = 8'h55;
    localparam logic [7:0] CSSC_LF_RESET       = 8'h00;
    localparam int         CSSC_PRIO_BIT       = 0;
    localparam int         CSSC_MODE_LSB       = 1;
    localparam int         CSSC_RSVD_BIT       = 3;
    localparam int         CSSC_SRC1_LSB       = 4;
    localparam int         CSSC_SRC2_LSB       = 6;
    localparam int         CSSC_ODIV_BIT       = 7;
    localparam int         CSSC_ADD_LSB        = 4;
    localparam int         CSSC_SETTLE_CYCLES  = 4;
    typedef enum logic [1:0] {
        CSSC_SRC_INPUT,
        CSSC_SRC_PLL_A,
        CSSC_SRC_PLL_B,
        CSSC_SRC_PLL_C
    } cssc_src_t;
endpackage : cssc_pkg

/* cssc_glitchless_mux.sv */
// Two-input clock selector with break-before-make handoff; enables switch on the system clock, not on either input clock
`timescale 1ns/1ns
`default_nettype none
module cssc_glitchless_mux
    import cssc_pkg::*;
(
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic select_b,
    input  wire logic clk_a,
    input  wire logic clk_b,
    output logic      active_b,
    output logic      clk_out
);
    logic en_a_reg;
    logic en_b_reg;
    logic en_a_next;
    logic en_b_next;
    logic active_b_reg;

    // Enable a side only once the other side is fully off
    assign en_a_next = !select_b && !en_b_reg;
    assign en_b_next = select_b && !en_a_reg;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            en_a_reg     <= 1'b1;
            en_b_reg     <= 1'b0;
            active_b_reg <= 1'b0;
        end else begin
            en_a_reg     <= en_a_next;
            en_b_reg     <= en_b_next;
            active_b_reg <= en_b_reg;
        end
    end

    assign clk_out  = (clk_a & en_a_reg) | (clk_b & en_b_reg);
    assign active_b = active_b_reg;

    no_overlap_a: assert property (@(posedge clock) disable iff (reset)
        !(en_a_reg && en_b_reg)) else $error("both clock enables high");
endmodule : cssc_glitchless_mux
`default_nettype wire

/* cssc_clock_source_select_tb.sv */
// Self-checking testbench for the clock source select configuration slice
`timescale 1ns/1ns
`default_nettype none
module cssc_clock_source_select_tb;
    import cssc_pkg::*;
    logic        clock, reset, reg_write, mfc_mode, pins_en, xtal, second;
    logic        xtal_good, second_good, pll_a, pll_b, pll_c;
    logic        selected_input_clock, second_input_active, divider_config_choice;
    logic [1:0]  config_select_pins;
    logic [3:0]  add_field;
    logic [5:0]  divider_clock;
    logic [6:0]  pll_c_loop_filter;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [11:0] int_field, divider_source_select;
    logic [13:0] pll_b_multiplier;
    logic [7:0]  lf_val [4] = '{8'h95, 8'h1a, 8'hac, 8'h73};
    logic [7:0]  rv [9] = '{8'h00, 8'h00, 8'h46, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  ra [9] = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h36};
    int          fail_count = 0;
    int          n_checks = 0;

    cssc_clock_source_select #(.DIVIDERS(6)) dut (
        .clock(clock), .reset(reset), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .multi_function_config_mode(mfc_mode),
        .config_pins_enable(pins_en), .config_select_pins(config_select_pins),
        .feedback_integer_field(int_field), .feedback_fraction_add(add_field),
        .crystal_reference_input(xtal), .second_clock_input(second),
        .crystal_good(xtal_good), .second_good(second_good), .pll_a_clock(pll_a),
        .pll_b_clock(pll_b), .pll_c_clock(pll_c), .selected_input_clock(selected_input_clock),
        .second_input_active(second_input_active), .divider_clock(divider_clock),
        .divider_source_select(divider_source_select), .pll_c_loop_filter(pll_c_loop_filter),
        .divider_config_choice(divider_config_choice), .pll_b_multiplier(pll_b_multiplier));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        xtal = 1'b0;
        forever #15 xtal = ~xtal;
    end
    initial begin
        second = 1'b0;
        forever #35 second = ~second;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        @(negedge clock);
        chk({8'h00, reg_rdata}, {8'h00, exp});
        @(posedge clock);
    endtask : rd

    // Bounded wait for the active input, then check it
    task automatic wait_active(input logic exp);
        int i;
        for (i = 0; i < 20; i++) begin
            @(negedge clock);
            if (second_input_active === exp)
                break;
        end
        chk({15'h0, second_input_active}, {15'h0, exp});
        if (i == 20)
            tally_and_finish();
        @(posedge clock);
    endtask : wait_active

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : settle

    initial begin
        logic       e;
        logic       ein;
        {reset, reg_write, mfc_mode, pins_en, pll_a, pll_b, pll_c} = 7'b1000000;
        {xtal_good, second_good, config_select_pins, add_field} = 8'hf0;
        {reg_addr, reg_wdata, int_field} = 28'h0;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        for (int k = 0; k < 9; k++) rd(ra[k], rv[k]);
        chk({4'h0, divider_source_select}, 16'h0554);
        chk({15'h0, second_input_active}, 16'h0000);
        wr(8'h32, 8'ha7);
        wr(8'h33, 8'h5c);
        wr(8'h36, 8'hff);
        rd(8'h32, 8'ha7);
        rd(8'h33, 8'h5c);
        rd(8'h36, 8'h00);
        // Manual switching follows the priority bit
        wr(8'h34, 8'h41);
        wait_active(1'b1);
        wr(8'h34, 8'h40);
        wait_active(1'b0);
        wr(8'h34, 8'h43);
        wait_active(1'b1);
        wr(8'h34, 8'h42);
        wait_active(1'b0);
        // Automatic revertive, then non-revertive
        wr(8'h34, 8'h46);
        xtal_good <= 1'b0;
        wait_active(1'b1);
        xtal_good <= 1'b1;
        wait_active(1'b0);
        wr(8'h34, 8'h44);
        xtal_good <= 1'b0;
        wait_active(1'b1);
        xtal_good <= 1'b1;
        settle(12);
        chk({15'h0, second_input_active}, 16'h0001);
        @(posedge clock);
        second_good <= 1'b0;
        wait_active(1'b0);
        second_good <= 1'b1;
        // Divider routing for every source code
        for (int c = 0; c < 4; c++) begin
            wr(CSSC_ROUTE_ADDR, 8'(c * 8'h55));
            rd(CSSC_ROUTE_ADDR, 8'(c * 8'h55));
            chk({8'h00, divider_source_select[11:4]}, 16'(c * 8'h55));
            for (int p = 0; p < 3; p++) begin
                {pll_c, pll_b, pll_a} <= 3'(1 << p);
                @(negedge clock);
                #1;
                ein = second_input_active ? second : xtal;
                e = (c == 0) ? ein : (c - 1 == p);
                chk({10'h0, divider_clock}, {10'h0, {4{e}}, (p == 0), ein});
                @(posedge clock);
            end
        end
        // Multiplier from integer and add fields
        int_field <= 12'd100;
        settle(2);
        chk({2'b00, pll_b_multiplier}, 16'd200);
        @(posedge clock);
        add_field <= 4'd5;
        settle(2);
        chk({2'b00, pll_b_multiplier}, 16'd206);
        @(posedge clock);
        // Loop filter slots picked by the configuration pins
        for (int k = 0; k < 4; k++) wr(8'(8'h38 + k), lf_val[k]);
        for (int k = 0; k < 4; k++) rd(8'(8'h38 + k), lf_val[k]);
        {mfc_mode, pins_en} <= 2'b11;
        for (int k = 0; k < 4; k++) begin
            config_select_pins <= 2'(k);
            settle(2);
            chk({8'h00, divider_config_choice, pll_c_loop_filter}, {8'h00, lf_val[k]});
            @(posedge clock);
        end
        pins_en <= 1'b0;
        settle(2);
        chk({8'h00, divider_config_choice, pll_c_loop_filter}, {8'h00, lf_val[0]});
        @(posedge clock);
        mfc_mode <= 1'b0;
        settle(2);
        chk({15'h0, divider_config_choice}, 16'h0000);
        tally_and_finish();
    end
endmodule : cssc_clock_source_select_tb
`default_nettype wire
